// *** ble_pkg.sv ***
// Purpose: Shared constants for the bit logic controller engine
// Assumes: 100 MHz system clock, 16-bit parameter words
// Notes:   Parameter indexes and program encodings used by engine and assertions

package ble_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCAN_PERIOD_NS = 6144000;
  localparam int FAST_PERIOD_NS = 512000;
  localparam int SCAN_CYCLES    = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FAST_CYCLES    = FAST_PERIOD_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int PROG_SLOTS = 128;
  localparam int PAR_WORDS  = 256;

  // ---------------------------------------------------------------------------
  // Opcodes, slot layout: [15:12] opcode, [11:4] parameter, [3:0] bit
  // Arithmetic second slot: [15:8] second operand, [7:0] destination
  // Fast capture: [3:0] target bit, [5:4] mode
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OP_END           = 4'h0;
  localparam logic [3:0] OP_LOAD_BIT      = 4'h1;
  localparam logic [3:0] OP_LOAD_BIT_INV  = 4'h2;
  localparam logic [3:0] OP_WRITE_BIT     = 4'h3;
  localparam logic [3:0] OP_WRITE_BIT_INV = 4'h4;
  localparam logic [3:0] OP_SET           = 4'h5;
  localparam logic [3:0] OP_CLEAR_BIT     = 4'h6;
  localparam logic [3:0] OP_CONJ          = 4'h7;
  localparam logic [3:0] OP_CONJ_NEG      = 4'h8;
  localparam logic [3:0] OP_DISJ          = 4'h9;
  localparam logic [3:0] OP_DISJ_NEG      = 4'hA;
  localparam logic [3:0] OP_SUM           = 4'hB;
  localparam logic [3:0] OP_DIFFERENCE    = 4'hC;
  localparam logic [3:0] OP_PRODUCT       = 4'hD;
  localparam logic [3:0] OP_QUOTIENT      = 4'hE;
  localparam logic [3:0] OP_FAST_CAPTURE  = 4'hF;
  localparam int         FC_MODE_LSB      = 4;

  // ---------------------------------------------------------------------------
  // Parameter indexes and bit positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0] P_FAST_BANK_A = 8'h28;
  localparam logic [7:0] P_IN_STATUS   = 8'h5A;
  localparam logic [7:0] P_OUT_STATUS  = 8'h5B;
  localparam logic [7:0] P_TIMER_A     = 8'h5C;
  localparam logic [7:0] P_TIMER_B     = 8'h5D;
  localparam logic [7:0] P_CONTROL     = 8'h5E;
  localparam logic [7:0] P_STATUS      = 8'h63;
  localparam logic [7:0] P_FAST_BANK_B = 8'h96;
  localparam logic [7:0] P_CONST_FIRST = 8'h47;
  localparam logic [7:0] P_DW_A_LO     = 8'h3C;
  localparam logic [7:0] P_DW_A_HI     = 8'h45;
  localparam logic [7:0] P_DW_B_LO     = 8'h6E;
  localparam logic [7:0] P_DW_B_HI     = 8'h95;
  localparam int B_FORCE_DW  = 0;
  localparam int B_FA_DIS    = 5;
  localparam int B_FB_DIS    = 6;
  localparam int B_TA_DONE   = 0;
  localparam int B_TB_DONE   = 1;
  localparam int B_NEG       = 2;
  localparam int B_ZERO      = 3;
  localparam int B_RUN       = 13;
  localparam int N_INPUTS    = 4;
  localparam int N_OUTPUTS   = 2;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] STATUS_RST = 16'h2003;
  localparam logic [15:0] CONST_RST [9] = '{16'hFFFF, 16'h0000, 16'h0001, 16'h0002, 16'h000A,
                                            16'h0064, 16'h03E8, 16'h0400, 16'h1000};

  // ---------------------------------------------------------------------------
  // Register port map (10-bit word address)
  // ---------------------------------------------------------------------------
  localparam logic [1:0] A_SEL_PAR    = 2'h0;
  localparam logic [1:0] A_SEL_PROG   = 2'h1;
  localparam logic [9:0] A_ENG_STATUS = 10'h200;

endpackage

// *** ble_engine.sv ***
// Purpose: Scan-driven bit logic engine with one-bit stack and word arithmetic
// Assumes: Single 100 MHz clock, registers reached over a plain strobe port
// Notes:   Parameter table and program memory live here; no non-volatile store
`timescale 1ns/1ns
`default_nettype none

// Function
// (RULE1) Scan: inputs, timers, program, then outputs
// (RULE2) Logic instructions are single bit, one-bit stack
// (RULE3) load_bit pushes bit, load_bit_inverted its complement
// (RULE4) write_bit copies stack, write_bit_inverted its complement
// (RULE5) set/clear_bit_cond act only when stack is 1
// (RULE6) Conj/disj ops combine stack with (negated) bit
// (RULE7) Arithmetic runs only when stack is 1
// (RULE8) Default arithmetic is signed 16-bit words
// (RULE9) force_double_word applies once, then self-clears
// (RULE10) Destinations 60-69, 110-149 are implicit double words
// (RULE11) Double word: named low, next parameter high
// (RULE12) Flags negative and nonzero updated per arithmetic
// (RULE13) Constant destinations allowed to update flags
// (RULE14) Double-word quotient: quotient low, remainder high; code: remainder only with force_double_word, else quotient bits 31:16
// (RULE15) Two fast captures at fast period, first slots
// (RULE16) Capture input 0/1 into bank, mode 2 inverts
// (RULE17) Misplaced captures ignored; per-capture disable bits
// (RULE18) Timers decrement per scan, done at zero
// (RULE19) Timers change only just before execution
// (RULE20) 128 slots, arithmetic takes two slots
// (RULE21) Program ends with end instruction
// (RULE22) Program writes only while plc_run is 0
// (RULE23) Input user bits retained, output bits cleared
// (RULE24) plc_run selects execution or skip
// (RULE25) Sequential from slot zero; late scans wait
// (RULE26) Stack starts each scan at 0
module ble_engine #(
  parameter int SCAN_CYC = ble_pkg::SCAN_CYCLES,
  parameter int FAST_CYC = ble_pkg::FAST_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // Register port
  input  wire logic [9:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Digital pins
  input  wire logic [3:0]  i_din,
  output logic      [1:0]  o_dout,
  // Scan status
  output logic             o_scan_busy,
  output logic             o_scan_done
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_implicit_dw(input logic [7:0] idx);
    is_implicit_dw = (idx >= ble_pkg::P_DW_A_LO && idx <= ble_pkg::P_DW_A_HI) ||
                     (idx >= ble_pkg::P_DW_B_LO && idx <= ble_pkg::P_DW_B_HI);
  endfunction

  function automatic logic is_arith(input logic [3:0] op);
    is_arith = (op == ble_pkg::OP_SUM) || (op == ble_pkg::OP_DIFFERENCE) ||
               (op == ble_pkg::OP_PRODUCT) || (op == ble_pkg::OP_QUOTIENT);
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE, ST_SAMPLE, ST_TIMER, ST_FETCH, ST_OPND, ST_HIGH, ST_OUTPUT
  } ble_state_type;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [15:0] par_ff   [ble_pkg::PAR_WORDS];
  logic [15:0] prog_mem [ble_pkg::PROG_SLOTS];

  // ---------------------------------------------------------------------------
  // Input synchroniser, change accepted once stages two and three agree
  // ---------------------------------------------------------------------------
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] din_ff;
  logic [3:0] nxt_din;

  always_comb begin
    nxt_din = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & din_ff);
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_ff  <= 4'h0;
      s2_ff  <= 4'h0;
      s3_ff  <= 4'h0;
      din_ff <= 4'h0;
    end else begin
      s1_ff  <= i_din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      din_ff <= nxt_din;
    end
  end

  // ---------------------------------------------------------------------------
  // Scan and fast period tick generators
  // ---------------------------------------------------------------------------
  logic [19:0] scan_cnt_ff;
  logic [19:0] nxt_scan_cnt;
  logic [15:0] fast_cnt_ff;
  logic [15:0] nxt_fast_cnt;
  logic        scan_tick;
  logic        fast_tick;
  logic        pend_ff;
  logic        nxt_pend;
  logic        start;

  always_comb begin
    scan_tick    = (scan_cnt_ff == 20'(SCAN_CYC - 1));
    fast_tick    = (fast_cnt_ff == 16'(FAST_CYC - 1));
    nxt_scan_cnt = scan_tick ? 20'h00000 : scan_cnt_ff + 20'h00001;
    nxt_fast_cnt = fast_tick ? 16'h0000 : fast_cnt_ff + 16'h0001;
    // An overrunning scan leaves one tick pending, later ticks merge into it
    nxt_pend     = scan_tick | (pend_ff & ~start); // [RULE25]
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      scan_cnt_ff <= 20'h00000;
      fast_cnt_ff <= 16'h0000;
      pend_ff     <= 1'b0;
    end else begin
      scan_cnt_ff <= nxt_scan_cnt;
      fast_cnt_ff <= nxt_fast_cnt;
      pend_ff     <= nxt_pend;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  ble_state_type state_ff;
  ble_state_type nxt_state;
  logic [7:0]    pc_ff;
  logic [7:0]    nxt_pc;
  logic          stack_ff;
  logic          nxt_stack;
  logic [15:0]   ins_ff;
  logic [15:0]   nxt_ins;
  logic [15:0]   hi_ff;
  logic [15:0]   nxt_hi;
  logic [7:0]    dst_ff;
  logic [7:0]    nxt_dst;
  logic [1:0]    dout_ff;
  logic [1:0]    nxt_dout;
  logic          done_ff;
  logic          nxt_done;

  logic          run;
  logic [15:0]   slot;
  logic [3:0]    op;
  logic [7:0]    pa;
  logic [3:0]    yb;
  logic [15:0]   pword;
  logic          pbit;
  logic          eng_we;
  logic [7:0]    eng_addr;
  logic [15:0]   eng_wdata;
  logic          smp_upd;
  logic          tim_upd;
  logic          flag_we;
  logic          clr_force;

  // Arithmetic datapath
  logic [3:0]         aop;
  logic [7:0]         a_idx;
  logic [7:0]         b_idx;
  logic [7:0]         c_idx;
  logic               force_dw;
  logic               dw;
  logic signed [31:0] av;
  logic signed [31:0] bv;
  logic signed [31:0] res;
  logic signed [31:0] rem;
  logic               neg;
  logic               nz;

  always_comb begin
    run   = par_ff[ble_pkg::P_STATUS][ble_pkg::B_RUN];
    slot  = prog_mem[pc_ff[6:0]];
    op    = slot[15:12];
    pa    = slot[11:4];
    yb    = slot[3:0];
    pword = par_ff[pa];
    pbit  = pword[yb];
  end

  always_comb begin
    aop      = ins_ff[15:12];
    a_idx    = ins_ff[11:4];
    b_idx    = slot[15:8];
    c_idx    = slot[7:0];
    force_dw = par_ff[ble_pkg::P_CONTROL][ble_pkg::B_FORCE_DW];
    dw       = force_dw | is_implicit_dw(c_idx); // [RULE9] [RULE10]
    // Low word at the named index, high word at the next one
    if (force_dw) begin
      av = {par_ff[8'(a_idx + 8'h01)], par_ff[a_idx]}; // [RULE11]
      bv = {par_ff[8'(b_idx + 8'h01)], par_ff[b_idx]}; // [RULE11]
    end else begin
      av = 32'(signed'(par_ff[a_idx])); // [RULE8]
      bv = 32'(signed'(par_ff[b_idx])); // [RULE8]
    end
    rem = 32'sh0;
    case (aop)
      ble_pkg::OP_SUM:        res = av + bv;
      ble_pkg::OP_DIFFERENCE: res = av - bv;
      ble_pkg::OP_PRODUCT:    res = av * bv;
      ble_pkg::OP_QUOTIENT: begin
        // Divide by zero yields zero rather than trapping
        if (bv == 32'sh0) begin
          res = 32'sh0;
        end else begin
          res = av / bv;
          rem = av % bv;
        end
      end
      default:                res = 32'sh0;
    endcase
    neg = dw ? res[31] : res[15];            // [RULE12]
    nz  = dw ? (|res) : (|res[15:0]);        // [RULE12]
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    nxt_stack = stack_ff;
    nxt_ins   = ins_ff;
    nxt_hi    = hi_ff;
    nxt_dst   = dst_ff;
    nxt_dout  = dout_ff;
    nxt_done  = 1'b0;
    start     = 1'b0;
    eng_we    = 1'b0;
    eng_addr  = pa;
    eng_wdata = pword;
    smp_upd   = 1'b0;
    tim_upd   = 1'b0;
    flag_we   = 1'b0;
    clr_force = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (pend_ff) begin
          start     = 1'b1;
          nxt_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        smp_upd   = 1'b1; // [RULE1]
        nxt_state = ST_TIMER;
      end
      ST_TIMER: begin
        tim_upd   = 1'b1; // [RULE1] [RULE19]
        nxt_pc    = 8'h00; // [RULE25]
        nxt_stack = 1'b0; // [RULE26]
        nxt_state = run ? ST_FETCH : ST_OUTPUT; // [RULE24]
      end
      ST_FETCH: begin
        nxt_pc = pc_ff + 8'h01;
        if (pc_ff[7]) begin
          // Running off the end of memory closes the scan as an end would
          nxt_state = ST_OUTPUT; // [RULE20]
        end else begin
          case (op)
            ble_pkg::OP_END:          nxt_state = ST_OUTPUT; // [RULE21]
            ble_pkg::OP_LOAD_BIT:     nxt_stack = pbit; // [RULE3] [RULE2]
            ble_pkg::OP_LOAD_BIT_INV: nxt_stack = ~pbit; // [RULE3]
            ble_pkg::OP_WRITE_BIT: begin
              eng_we        = 1'b1;
              eng_wdata[yb] = stack_ff; // [RULE4]
            end
            ble_pkg::OP_WRITE_BIT_INV: begin
              eng_we        = 1'b1;
              eng_wdata[yb] = ~stack_ff; // [RULE4]
            end
            ble_pkg::OP_SET: begin
              eng_we        = stack_ff; // [RULE5]
              eng_wdata[yb] = 1'b1;
            end
            ble_pkg::OP_CLEAR_BIT: begin
              eng_we        = stack_ff; // [RULE5]
              eng_wdata[yb] = 1'b0;
            end
            ble_pkg::OP_CONJ:     nxt_stack = stack_ff & pbit; // [RULE6]
            ble_pkg::OP_CONJ_NEG: nxt_stack = stack_ff & ~pbit; // [RULE6]
            ble_pkg::OP_DISJ:     nxt_stack = stack_ff | pbit; // [RULE6]
            ble_pkg::OP_DISJ_NEG: nxt_stack = stack_ff | ~pbit; // [RULE6]
            ble_pkg::OP_FAST_CAPTURE: nxt_stack = stack_ff; // [RULE17]
            default: begin
              if (is_arith(op)) begin
                // Second slot holds the other operand and destination
                if (stack_ff) begin // [RULE7]
                  nxt_ins   = slot;
                  nxt_state = ST_OPND;
                end else begin
                  nxt_pc = pc_ff + 8'h02; // [RULE20]
                end
              end
            end
          endcase
        end
      end
      ST_OPND: begin
        nxt_pc    = pc_ff + 8'h01;
        eng_we    = 1'b1; // [RULE13]
        eng_addr  = c_idx;
        eng_wdata = res[15:0];
        flag_we   = 1'b1; // [RULE12]
        clr_force = force_dw; // [RULE9]
        nxt_dst   = 8'(c_idx + 8'h01);
        if (aop == ble_pkg::OP_QUOTIENT && force_dw) begin
          nxt_hi = rem[15:0]; // [RULE14]
        end else begin
          nxt_hi = res[31:16]; // [RULE10]
        end
        nxt_state = dw ? ST_HIGH : ST_FETCH;
      end
      ST_HIGH: begin
        eng_we    = 1'b1; // [RULE11]
        eng_addr  = dst_ff;
        eng_wdata = hi_ff;
        nxt_state = ST_FETCH;
      end
      ST_OUTPUT: begin
        nxt_dout  = par_ff[ble_pkg::P_OUT_STATUS][1:0]; // [RULE1]
        nxt_done  = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
      pc_ff    <= 8'h00;
      stack_ff <= 1'b0;
      ins_ff   <= 16'h0000;
      hi_ff    <= 16'h0000;
      dst_ff   <= 8'h00;
      dout_ff  <= 2'h0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      stack_ff <= nxt_stack;
      ins_ff   <= nxt_ins;
      hi_ff    <= nxt_hi;
      dst_ff   <= nxt_dst;
      dout_ff  <= nxt_dout;
      done_ff  <= nxt_done;
    end
  end

  // ---------------------------------------------------------------------------
  // Fast captures, honoured only from slots 0 and 1
  // ---------------------------------------------------------------------------
  logic       fc0_en;
  logic       fc1_en;
  logic [1:0] fc0_mode;
  logic [1:0] fc1_mode;

  always_comb begin
    fc0_mode = prog_mem[0][ble_pkg::FC_MODE_LSB +: 2];
    fc1_mode = prog_mem[1][ble_pkg::FC_MODE_LSB +: 2];
    fc0_en   = fast_tick & run & (prog_mem[0][15:12] == ble_pkg::OP_FAST_CAPTURE) &
               ~par_ff[ble_pkg::P_CONTROL][ble_pkg::B_FA_DIS]; // [RULE15] [RULE17]
    fc1_en   = fast_tick & run & (prog_mem[0][15:12] == ble_pkg::OP_FAST_CAPTURE) &
               (prog_mem[1][15:12] == ble_pkg::OP_FAST_CAPTURE) &
               ~par_ff[ble_pkg::P_CONTROL][ble_pkg::B_FB_DIS]; // [RULE15] [RULE17]
  end

  // ---------------------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------------------
  logic        par_we;
  logic        prog_we;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        busy_ff;
  logic        nxt_busy;

  always_comb begin
    par_we  = i_wr & (i_addr[9:8] == ble_pkg::A_SEL_PAR);
    // Program edits refused while running or mid-scan
    prog_we = i_wr & (i_addr[9:8] == ble_pkg::A_SEL_PROG) & ~i_addr[7] & ~run &
              (state_ff == ST_IDLE); // [RULE22]
    nxt_busy = (nxt_state != ST_IDLE);
    if (!i_rd) begin
      nxt_rdata = 16'h0000;
    end else if (i_addr[9:8] == ble_pkg::A_SEL_PAR) begin
      nxt_rdata = par_ff[i_addr[7:0]];
    end else if (i_addr[9:8] == ble_pkg::A_SEL_PROG && !i_addr[7]) begin
      nxt_rdata = prog_mem[i_addr[6:0]];
    end else if (i_addr == ble_pkg::A_ENG_STATUS) begin
      nxt_rdata = {15'h0000, busy_ff};
    end else begin
      nxt_rdata = 16'h0000;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= 16'h0000;
      busy_ff  <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      busy_ff  <= nxt_busy;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (prog_we) begin
      prog_mem[i_addr[6:0]] <= i_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Parameter table; later writes in this block take precedence
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      // No backing store: retained user bits also start from zero here
      for (int i = 0; i < ble_pkg::PAR_WORDS; i++) begin
        par_ff[i] <= 16'h0000; // [RULE23]
      end
      for (int k = 0; k < 9; k++) begin
        par_ff[int'(ble_pkg::P_CONST_FIRST) + k] <= ble_pkg::CONST_RST[k];
      end
      par_ff[ble_pkg::P_STATUS] <= ble_pkg::STATUS_RST;
    end else begin
      if (smp_upd) begin
        // Only the pin bits refresh, user bits 4..15 are kept
        par_ff[ble_pkg::P_IN_STATUS][3:0] <= din_ff; // [RULE23] [RULE1]
      end
      if (tim_upd) begin
        if (par_ff[ble_pkg::P_TIMER_A] != 16'h0000) begin
          par_ff[ble_pkg::P_TIMER_A] <= par_ff[ble_pkg::P_TIMER_A] - 16'h0001; // [RULE18]
        end
        if (par_ff[ble_pkg::P_TIMER_B] != 16'h0000) begin
          par_ff[ble_pkg::P_TIMER_B] <= par_ff[ble_pkg::P_TIMER_B] - 16'h0001; // [RULE18]
        end
        par_ff[ble_pkg::P_STATUS][ble_pkg::B_TA_DONE] <= (par_ff[ble_pkg::P_TIMER_A] <= 16'h0001); // [RULE18]
        par_ff[ble_pkg::P_STATUS][ble_pkg::B_TB_DONE] <= (par_ff[ble_pkg::P_TIMER_B] <= 16'h0001); // [RULE18]
      end
      if (eng_we) begin
        par_ff[eng_addr] <= eng_wdata;
      end
      if (flag_we) begin
        par_ff[ble_pkg::P_STATUS][ble_pkg::B_NEG]  <= neg; // [RULE12]
        par_ff[ble_pkg::P_STATUS][ble_pkg::B_ZERO] <= nz; // [RULE12]
      end
      if (clr_force) begin
        par_ff[ble_pkg::P_CONTROL][ble_pkg::B_FORCE_DW] <= 1'b0; // [RULE9]
      end
      if (fc0_en) begin
        par_ff[fc0_mode[0] ? ble_pkg::P_FAST_BANK_B : ble_pkg::P_FAST_BANK_A][prog_mem[0][3:0]]
          <= din_ff[0] ^ fc0_mode[1]; // [RULE16]
      end
      if (fc1_en) begin
        par_ff[fc1_mode[0] ? ble_pkg::P_FAST_BANK_B : ble_pkg::P_FAST_BANK_A][prog_mem[1][3:0]]
          <= din_ff[1] ^ fc1_mode[1]; // [RULE16]
      end
      if (par_we) begin
        par_ff[i_addr[7:0]] <= i_wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_rdata     = rdata_ff;
  assign o_dout      = dout_ff;
  assign o_scan_busy = busy_ff;
  assign o_scan_done = done_ff;

endmodule

`default_nettype wire

// *** ble_engine_asserts.sv ***
// Purpose: Port-level checks for ble_engine
// Assumes: Read data one cycle after the read strobe
// Notes:   Bound into every ble_engine instance
`timescale 1ns/1ns
`default_nettype none
module ble_engine_asserts #(
  parameter int SCAN_CYC = ble_pkg::SCAN_CYCLES,
  parameter int FAST_CYC = ble_pkg::FAST_CYCLES
) (
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic [9:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [3:0]  i_din,
  input wire logic [1:0]  o_dout,
  input wire logic        o_scan_busy,
  input wire logic        o_scan_done
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // Longest legal scan is well under 300 cycles
  logic [8:0] busy_cnt_ff;
  logic [8:0] nxt_busy_cnt;
  always_comb nxt_busy_cnt = o_scan_busy ? busy_cnt_ff + 9'h1 : 9'h0;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) busy_cnt_ff <= 9'h0;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_status_read: assert property (i_rd && i_addr == ble_pkg::A_ENG_STATUS |=> o_rdata == {15'h0000, $past(o_scan_busy)})
    else $error("engine status read wrong");
  a_unmapped_read: assert property (i_rd && i_addr[9:8] == 2'h3 |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_done_pulse: assert property (o_scan_done |=> !o_scan_done)
    else $error("scan done longer than one cycle");
  a_done_ends_scan: assert property ($fell(o_scan_busy) |-> o_scan_done)
    else $error("scan ended without done");
  a_dout_at_done: assert property (!o_scan_done |-> $stable(o_dout))
    else $error("outputs changed outside scan end");
  a_scan_phases: assert property ($rose(o_scan_busy) |-> o_scan_busy[*2])
    else $error("scan shorter than its phases");
  a_scan_bound: assert property (busy_cnt_ff <= 9'h12C)
    else $error("scan runs too long");
endmodule
bind ble_engine ble_engine_asserts #(.SCAN_CYC(SCAN_CYC), .FAST_CYC(FAST_CYC)) ble_engine_asserts_inst (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_din(i_din), .o_dout(o_dout), .o_scan_busy(o_scan_busy),
  .o_scan_done(o_scan_done));
`default_nettype wire

// *** test_bit_logic_controller_engine.sv ***
// Purpose: Self-checking bench for ble_engine
// Assumes: Short scan of 200 cycles, fast tick of 20
// Notes:   Reads and outputs checked against queued notes
`timescale 1ns/1ns
`default_nettype none
module test_bit_logic_controller_engine;
  logic        i_clk_sys, i_nrst, i_wr, i_rd, rd_d, nf, zf;
  logic [9:0]  i_addr;
  logic [15:0] i_wdata, o_rdata, a, b, s, tcnt;
  logic [3:0]  i_din, d;
  logic [1:0]  o_dout;
  logic        o_scan_busy, o_scan_done;
  logic [31:0] p;
  logic [15:0] exp_q[$];
  logic [1:0]  dout_q[$];
  int          fails, n_compared, seed;
  // Slot 5 is a misplaced capture that must do nothing
  logic [15:0] prog [30] = '{16'hF002, 16'hF035, 16'h15A0, 16'h35B0, 16'h45B1, 16'hF009, 16'h15A2,
                             16'h35B3, 16'h35B4, 16'h15A3, 16'h55B3, 16'h65B4, 16'h75A0, 16'h85A1,
                             16'h95A2, 16'hA5A0, 16'h35B5, 16'h163D, 16'h55E0, 16'hE4D0, 16'h4856,
                             16'hC500, 16'h5153, 16'h15A1, 16'hB500, 16'h5152, 16'h25A1, 16'hD500,
                             16'h513C, 16'h0000};
  ble_engine #(.SCAN_CYC(200), .FAST_CYC(20)) ble_engine_inst (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_din(i_din), .o_dout(o_dout), .o_scan_busy(o_scan_busy),
    .o_scan_done(o_scan_done));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_dout(input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH o_dout expected %h seen %h", e, g);
    end
  endtask
  task automatic results;
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [9:0] ad, input logic [15:0] dt);
    @(posedge i_clk_sys);
    i_addr <= ad;
    i_wdata <= dt;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] ad, input logic [15:0] e);
    @(posedge i_clk_sys);
    exp_q.push_back(e);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (o_scan_done !== 1'b1 && k < 1000);
    if (o_scan_done !== 1'b1) begin
      fails++;
      results();
    end
  endtask
  always @(posedge i_clk_sys) begin
    if (rd_d === 1'b1) chk("o_rdata", exp_q.pop_front(), o_rdata);
    if (o_scan_done === 1'b1) chk_dout(dout_q.pop_front(), o_dout);
    rd_d <= i_rd;
  end
  initial begin
    seed = 59;
    fails = 0;
    n_compared = 0;
    {i_nrst, i_wr, i_rd, rd_d, i_addr, i_wdata, i_din} = '0;
    s = 16'h0;
    p = 32'h0;
    tcnt = 16'h3;
    repeat (5) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    wr(10'h063, 16'h0003);
    dout_q.push_back(2'h0);
    wait_done();
    foreach (prog[i]) wr(10'(10'h100 + i), prog[i]);
    wr(10'h05A, 16'hABC0);
    wr(10'h05C, 16'h0003);
    wr(10'h063, 16'h2003);
    for (int n = 0; n < 10; n++) begin
      d = 4'($random(seed));
      a = 16'($random(seed));
      b = 16'($random(seed));
      i_din <= d;
      wr(10'h050, a);
      wr(10'h051, b);
      dout_q.push_back({~d[0], d[0]});
      if (d[1]) begin
        s = a + b;
        nf = s[15];
        zf = (s != 16'h0);
      end else begin
        p = $signed(a) * $signed(b);
        nf = p[31];
        zf = (p != 32'h0);
      end
      tcnt = (tcnt != 16'h0) ? tcnt - 16'h1 : 16'h0;
      wait_done();
      rd(10'h05A, {12'hABC, d});
      rd(10'h05B, {10'h0, (d[3] & d[0] & ~d[1]) | d[2] | ~d[0], d[2] & ~d[3], d[2] | d[3],
                   1'b0, ~d[0], d[0]});
      rd(10'h052, s);
      rd(10'h053, a - b);
      rd(10'h056, 16'h0400);
      rd(10'h057, 16'h03E8);
      rd(10'h05E, 16'h0000);
      rd(10'h03C, p[15:0]);
      rd(10'h03D, p[31:16]);
      rd(10'h063, {3'h1, 9'h0, zf, nf, 1'b1, tcnt == 16'h0});
      rd(10'h05C, tcnt);
      rd(10'h028, {13'h0, d[0], 2'h0});
      rd(10'h096, {10'h0, ~d[1], 5'h0});
    end
    wr(10'h102, 16'hFFFF);
    rd(10'h102, 16'h15A0);
    rd(10'h300, 16'h0000);
    rd(10'h200, 16'h0000);
    repeat (2) @(posedge i_clk_sys);
    results();
  end
endmodule
`default_nettype wire
